// [design/isb_intr_status.sv]
// Interrupt status bits: sticky event flags, level flags, mask and one interrupt output,
// reached over an AHB-Lite slave port.
// Assumes the PHY interrupt and GPIO pins are asynchronous; the data port done pulse,
// MAC fault status and USB TX frame indication come from logic on the same clock.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module isb_intr_status
	import isb_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [ISB_ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [ISB_DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [ISB_DATA_W-1:0] hrdata,
	// Event sources
	input wire logic phy_irq_in_n,
	input wire logic dataport_done,
	input wire logic [ISB_MAC_FAULT_W-1:0] mac_fault_status,
	input wire logic usb_tx_frame_waiting,
	input wire logic [ISB_GPIO_N-1:0] gpio_pin_in,
	// Wake event clear, one pulse per pin, toward the GPIO block
	output logic [ISB_GPIO_N-1:0] pin_wake_clear,
	output logic irq_out
);

	function automatic logic hit(input logic [ISB_ADDR_W-1:0] a, input logic [ISB_DEC_W-1:0] ofs);
		hit = (a[ISB_DEC_W-1:0] == ofs) && (a[ISB_ADDR_W-1:ISB_DEC_W] == '0);
	endfunction

	logic [1:0] phy_sync_reg;
	logic [ISB_GPIO_N-1:0] gpio_meta_reg;
	logic [ISB_GPIO_N-1:0] gpio_sync_reg;
	logic phy_event_flag_reg;
	logic dataport_done_flag_reg;
	logic mac_fault_flag_reg;
	logic utx_reg;
	logic [ISB_GPIO_N-1:0] pin_event_flag_reg;
	logic [ISB_DATA_W-1:0] mask_reg;
	logic [ISB_DATA_W-1:0] status_view;
	logic wr_pend_reg;
	logic [ISB_DEC_W-1:0] wr_ofs_reg;
	logic [ISB_DATA_W-1:0] hrdata_reg;
	logic irq_reg;
	logic addr_take;
	logic bad_addr;
	logic status_wr;
	logic mask_wr;
	logic [ISB_DATA_W-1:0] clr_bits;

	// Pin inputs pass two flops before any logic reads them
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// Idle level of the active-low pin, so leaving reset raises no false event
			phy_sync_reg <= '1;
			gpio_meta_reg <= '0;
			gpio_sync_reg <= '0;
		end else begin
			phy_sync_reg <= {phy_sync_reg[0], phy_irq_in_n};
			gpio_meta_reg <= gpio_pin_in;
			gpio_sync_reg <= gpio_meta_reg;
		end
	end

	// Bus address phase
	assign addr_take = hsel && hready && (htrans == ISB_HTRANS_NONSEQ);
	// Only whole-word writes land; a narrow one would clear flags it never meant to touch
	assign bad_addr = !(hit(haddr, ISB_OFS_STATUS) || hit(haddr, ISB_OFS_MASK)) ||
		(hsize != ISB_HSIZE_WORD);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_reg <= 1'b0;
			wr_ofs_reg <= '0;
		end else if (hready) begin
			wr_pend_reg <= addr_take && hwrite && !bad_addr;
			wr_ofs_reg <= haddr[ISB_DEC_W-1:0];
		end
	end

	// Data phase of a write; hwdata is valid now
	assign status_wr = wr_pend_reg && (wr_ofs_reg == ISB_OFS_STATUS);
	assign mask_wr = wr_pend_reg && (wr_ofs_reg == ISB_OFS_MASK);
	assign clr_bits = status_wr ? (hwdata & ISB_W1C_MASK) : '0;

	// active-low pin level; set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phy_event_flag_reg <= 1'b0;
		end else if (!phy_sync_reg[1]) begin
			phy_event_flag_reg <= 1'b1;
		end else if (clr_bits[ISB_BIT_PHY]) begin
			phy_event_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dataport_done_flag_reg <= 1'b0;
		end else if (dataport_done) begin
			dataport_done_flag_reg <= 1'b1;
		end else if (clr_bits[ISB_BIT_DP]) begin
			dataport_done_flag_reg <= 1'b0;
		end
	end

	// level follows source; software clears the fault register, not this bit
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mac_fault_flag_reg <= 1'b0;
		end else begin
			mac_fault_flag_reg <= |mac_fault_status;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			utx_reg <= 1'b0;
		end else begin
			utx_reg <= usb_tx_frame_waiting;
		end
	end

	// One sticky flag per GPIO pin
	genvar g;
	generate
		for (g = 0; g < ISB_GPIO_N; g++) begin : g_pin
			// level sets it every cycle the pin is high
			// reset clears the flag; it sets again once the synchronised pin is high
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					pin_event_flag_reg[g] <= 1'b0;
				end else if (gpio_sync_reg[g]) begin
					pin_event_flag_reg[g] <= 1'b1;
				end else if (clr_bits[ISB_GPIO_LSB+g]) begin
					pin_event_flag_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	assign pin_wake_clear = clr_bits[ISB_GPIO_LSB +: ISB_GPIO_N];

	always_comb begin
		status_view = '0;
		status_view[ISB_BIT_PHY] = phy_event_flag_reg;
		status_view[ISB_BIT_DP] = dataport_done_flag_reg;
		status_view[ISB_BIT_MAC] = mac_fault_flag_reg;
		status_view[ISB_BIT_UTX] = utx_reg;
		status_view[ISB_GPIO_LSB +: ISB_GPIO_N] = pin_event_flag_reg;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mask_reg <= ISB_MASK_RST;
		end else if (mask_wr) begin
			mask_reg <= hwdata & ISB_LIVE_MASK;
		end
	end

	// Read data is latched at the address phase so the data phase needs no wait state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hrdata_reg <= '0;
		end else if (addr_take && !hwrite) begin
			if (hit(haddr, ISB_OFS_STATUS)) begin
				hrdata_reg <= status_view & ISB_LIVE_MASK;
			end else if (hit(haddr, ISB_OFS_MASK)) begin
				hrdata_reg <= mask_reg;
			end else begin
				hrdata_reg <= '0;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_view & mask_reg);
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = ISB_HRESP_OKAY;
	assign hrdata = hrdata_reg;
	assign irq_out = irq_reg;

	// Checks
	sequence s_phy_low;
		!phy_sync_reg[1];
	endsequence

	sequence s_clear_phy;
		clr_bits[ISB_BIT_PHY] && phy_sync_reg[1];
	endsequence

	chk_phy_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
		s_phy_low |=> phy_event_flag_reg)
		else $error("PHY pin low did not set the PHY flag");

	chk_phy_pin_sync: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(phy_irq_in_n) ##1 !phy_irq_in_n ##1 !phy_irq_in_n |=> phy_event_flag_reg)
		else $error("PHY pin held low did not reach the flag in time");

	chk_phy_clear: assert property (@(posedge clock) disable iff (!reset_n)
		s_clear_phy |=> !phy_event_flag_reg)
		else $error("PHY flag not cleared by write of one");

	chk_dp_pulse_hold: assert property (@(posedge clock) disable iff (!reset_n)
		dataport_done ##1 (!clr_bits[ISB_BIT_DP] && !dataport_done) [*3]
			|-> dataport_done_flag_reg)
		else $error("Data port flag lost before a clear");

	chk_mac_level: assert property (@(posedge clock) disable iff (!reset_n)
		|mac_fault_status |=> mac_fault_flag_reg)
		else $error("MAC fault did not raise the MAC flag");

	chk_mac_drops: assert property (@(posedge clock) disable iff (!reset_n)
		(mac_fault_status == '0) |=> !mac_fault_flag_reg)
		else $error("MAC flag stayed up with no fault bit set");

	chk_utx_follow: assert property (@(posedge clock) disable iff (!reset_n)
		##1 status_view[ISB_BIT_UTX] == $past(usb_tx_frame_waiting))
		else $error("Frame waiting bit does not follow its source");

	chk_gpio_level: assert property (@(posedge clock) disable iff (!reset_n)
		gpio_pin_in[0] [*4] |=> pin_event_flag_reg[0])
		else $error("GPIO level did not set its flag");

	chk_gpio_clear: assert property (@(posedge clock) disable iff (!reset_n)
		clr_bits[ISB_GPIO_LSB] && !gpio_sync_reg[0] |=> !pin_event_flag_reg[0])
		else $error("GPIO flag not cleared by write of one");

	chk_gpio_reset_val: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(reset_n) ##0 gpio_pin_in[0] [*3] |=> pin_event_flag_reg[0])
		else $error("GPIO flag after reset does not follow the pin");

	chk_wake_clear: assert property (@(posedge clock) disable iff (!reset_n)
		status_wr && hwdata[ISB_GPIO_LSB] |-> pin_wake_clear[0])
		else $error("Clearing a GPIO flag did not clear its wake event");

	chk_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
		addr_take && !hwrite && hit(haddr, ISB_OFS_STATUS) |=> hrdata[14:13] == 2'h0)
		else $error("Reserved status bits read nonzero");

	chk_zero_keeps: assert property (@(posedge clock) disable iff (!reset_n)
		dataport_done_flag_reg && status_wr && !hwdata[ISB_BIT_DP] |=> dataport_done_flag_reg)
		else $error("Writing zero cleared the data port flag");

	chk_irq_masked: assert property (@(posedge clock) disable iff (!reset_n)
		##1 irq_out == $past(|(status_view & mask_reg)))
		else $error("Interrupt output does not match masked status");

	// Bus, register and hold checks
	sequence s_status_wr_addr;
		addr_take && hwrite && hit(haddr, ISB_OFS_STATUS) && (hsize == ISB_HSIZE_WORD);
	endsequence

	chk_bus_okay: assert property (@(posedge clock) disable iff (!reset_n)
		hreadyout && (hresp == ISB_HRESP_OKAY))
		else $error("Bus slave inserted a wait or an error response");

	chk_wr_data_phase: assert property (@(posedge clock) disable iff (!reset_n)
		s_status_wr_addr |=> status_wr)
		else $error("Status write address phase not followed by its data phase");

	chk_phy_holds: assert property (@(posedge clock) disable iff (!reset_n)
		phy_event_flag_reg && !clr_bits[ISB_BIT_PHY] |=> phy_event_flag_reg)
		else $error("PHY flag dropped without a clear");

	chk_phy_no_spur: assert property (@(posedge clock) disable iff (!reset_n)
		phy_sync_reg[1] && !phy_event_flag_reg |=> !phy_event_flag_reg)
		else $error("PHY flag set while the pin was idle");

	chk_dp_clear: assert property (@(posedge clock) disable iff (!reset_n)
		clr_bits[ISB_BIT_DP] && !dataport_done |=> !dataport_done_flag_reg)
		else $error("Data port flag not cleared by write of one");

	chk_dp_no_spur: assert property (@(posedge clock) disable iff (!reset_n)
		!dataport_done && !dataport_done_flag_reg |=> !dataport_done_flag_reg)
		else $error("Data port flag set without a done pulse");

	chk_gpio_holds: assert property (@(posedge clock) disable iff (!reset_n)
		pin_event_flag_reg[0] && !clr_bits[ISB_GPIO_LSB] |=> pin_event_flag_reg[0])
		else $error("GPIO flag dropped without a clear");

	chk_gpio_no_spur: assert property (@(posedge clock) disable iff (!reset_n)
		!gpio_sync_reg[0] && !pin_event_flag_reg[0] |=> !pin_event_flag_reg[0])
		else $error("GPIO flag set while its pin was low");

	chk_wake_only_write: assert property (@(posedge clock) disable iff (!reset_n)
		!status_wr |-> (pin_wake_clear == '0))
		else $error("Wake clear pulsed outside a status write");

	chk_mask_written: assert property (@(posedge clock) disable iff (!reset_n)
		mask_wr |=> mask_reg == ($past(hwdata) & ISB_LIVE_MASK))
		else $error("Mask register did not take the written word");

	chk_mask_hold: assert property (@(posedge clock) disable iff (!reset_n)
		!mask_wr |=> $stable(mask_reg))
		else $error("Mask register changed without a write");

	chk_hrdata_hold: assert property (@(posedge clock) disable iff (!reset_n)
		!(addr_take && !hwrite) |=> $stable(hrdata))
		else $error("Read data changed without a read");

	chk_high_bits_zero: assert property (@(posedge clock) disable iff (!reset_n)
		addr_take && !hwrite && hit(haddr, ISB_OFS_STATUS) |=>
			hrdata[ISB_DATA_W-1:ISB_BIT_PHY+1] == '0)
		else $error("Status bits above the PHY flag read nonzero");

	chk_irq_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		(mask_reg == '0) |=> !irq_out)
		else $error("Interrupt raised with every source masked");

	chk_irq_rises: assert property (@(posedge clock) disable iff (!reset_n)
		|(status_view & mask_reg) |=> irq_out)
		else $error("Unmasked status did not raise the interrupt");

endmodule

`default_nettype wire

// [common/isb_pkg.sv]
// Constants for the interrupt status bit block: register map, field layout, reset values.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package isb_pkg;
	localparam int ISB_DATA_W = 32;
	localparam int ISB_ADDR_W = 32;
	localparam int ISB_GPIO_N = 12;
	localparam int ISB_MAC_FAULT_W = 32;
	localparam int ISB_DEC_W = 8;
	// Byte offsets of the registers
	localparam logic [ISB_DEC_W-1:0] ISB_OFS_STATUS = 8'h00;
	localparam logic [ISB_DEC_W-1:0] ISB_OFS_MASK = 8'h04;
	// Field positions in the status and mask layout
	localparam int ISB_BIT_PHY = 17;
	localparam int ISB_BIT_DP = 16;
	localparam int ISB_BIT_MAC = 15;
	localparam int ISB_BIT_UTX = 12;
	localparam int ISB_GPIO_LSB = 0;
	// Bits that software may clear by writing one
	localparam logic [ISB_DATA_W-1:0] ISB_W1C_MASK = 32'h0003_0fff;
	// Bits that exist in the layout at all; the rest read as zero
	localparam logic [ISB_DATA_W-1:0] ISB_LIVE_MASK = 32'h0003_9fff;
	localparam logic [ISB_DATA_W-1:0] ISB_STATUS_RST = 32'h0000_0000;
	localparam logic [ISB_DATA_W-1:0] ISB_MASK_RST = 32'h0000_0000;
	// AHB-Lite encodings
	localparam logic [1:0] ISB_HTRANS_NONSEQ = 2'h2;
	localparam logic ISB_HRESP_OKAY = 1'h0;
	localparam logic [2:0] ISB_HSIZE_WORD = 3'h2;
	localparam logic [1:0] ISB_WORD_ALIGN = 2'h0;
endpackage

// [verification/test_isb_intr_status.sv]
// Testbench for the interrupt status block: bus tasks note expected results in a queue,
// a monitor compares them in each data phase (hrdata, or irq_out and wake pulses).
// Assumes zero-wait AHB-Lite answers and a registered irq_out.
`timescale 1ns/1ns
`default_nettype none
module test_isb_intr_status;
	import isb_pkg::*;
	logic clock, reset_n, hsel, hwrite, hreadyout, hresp, irq_out;
	logic phy_n, dp_done, usb_fw, dph, dph_wr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, mac, got, want, m;
	logic [11:0] gpio, wake, g;
	logic [31:0] exp_q[$];
	int num_errors, comparisons;
	isb_intr_status i_dut(.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phy_irq_in_n(phy_n),
		.dataport_done(dp_done), .mac_fault_status(mac), .usb_tx_frame_waiting(usb_fw),
		.gpio_pin_in(gpio), .pin_wake_clear(wake), .irq_out(irq_out));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Writes are judged by irq_out and the wake pulses seen in their data phase
	always @(posedge clock) begin
		if (dph) begin
			got = dph_wr ? {19'h0, irq_out, wake} : hrdata;
			want = exp_q.pop_front();
			comparisons++;
			if (got !== want) begin
				num_errors++;
				$display("wrong value at %0t: got %h expected %h", $time, got, want);
			end
			if (hresp !== ISB_HRESP_OKAY) begin
				num_errors++;
				$display("wrong value at %0t: got %h expected %h", $time, hresp, ISB_HRESP_OKAY);
			end
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] e);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= ISB_HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		dph <= 1'b1;
		dph_wr <= w;
		exp_q.push_back(e);
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		dph <= 1'b0;
		@(posedge clock);
	endtask
	task automatic pulse_dp();
		dp_done <= 1'b1;
		@(posedge clock);
		dp_done <= 1'b0;
		tick(3);
	endtask
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Watchdog: the tests need under two hundred cycles
	initial begin
		#40000;
		num_errors++;
		wrap_up();
	end
	initial begin
		reset_n = 1'b0;
		{hsel, hwrite, dph, dph_wr, dp_done, usb_fw} = 6'h0;
		{haddr, hwdata, mac} = 96'h0;
		htrans = 2'h0;
		hsize = ISB_HSIZE_WORD;
		phy_n = 1'b1;
		gpio = 12'h0;
		void'($urandom(44));
		tick(5);
		reset_n <= 1'b1;
		@(posedge clock);
		xfer(1'b0, 32'h0, 32'h0, 32'h0);
		xfer(1'b1, 32'h4, 32'hffff_ffff, 32'h0);
		xfer(1'b0, 32'h4, 32'h0, 32'h0003_9fff);
		xfer(1'b1, 32'h4, 32'h0, 32'h0);
		xfer(1'b0, 32'h8, 32'h0, 32'h0);
		$display("test reset and map done");
		phy_n <= 1'b0;
		tick(4);
		phy_n <= 1'b1;
		tick(4);
		xfer(1'b0, 32'h0, 32'h0, 32'h0002_0000);
		xfer(1'b1, 32'h0, 32'h0002_0000, 32'h0);
		xfer(1'b0, 32'h0, 32'h0, 32'h0);
		pulse_dp();
		xfer(1'b1, 32'h0, 32'h0, 32'h0);
		xfer(1'b0, 32'h0, 32'h0, 32'h0001_0000);
		xfer(1'b1, 32'h0, 32'h0001_0000, 32'h0);
		xfer(1'b0, 32'h0, 32'h0, 32'h0);
		$display("test phy and data port done");
		m = $urandom() | 32'h1;
		mac <= m;
		tick(3);
		xfer(1'b1, 32'h0, 32'h0000_8000, 32'h0);
		xfer(1'b0, 32'h0, 32'h0, 32'h0000_8000);
		mac <= 32'h0;
		tick(3);
		xfer(1'b0, 32'h0, 32'h0, 32'h0);
		usb_fw <= 1'b1;
		tick(3);
		xfer(1'b1, 32'h0, 32'hffff_ffff, 32'h0000_0fff);
		xfer(1'b0, 32'h0, 32'h0, 32'h0000_1000);
		usb_fw <= 1'b0;
		tick(3);
		xfer(1'b0, 32'h0, 32'h0, 32'h0);
		$display("test mac and usb done");
		g = 12'($urandom()) | 12'h001;
		gpio <= g;
		tick(4);
		gpio <= 12'h0;
		tick(3);
		xfer(1'b0, 32'h0, 32'h0, {20'h0, g});
		xfer(1'b1, 32'h0, {20'h0, g}, {20'h0, g});
		xfer(1'b0, 32'h0, 32'h0, 32'h0);
		gpio <= 12'h800;
		tick(4);
		xfer(1'b1, 32'h0, 32'h0000_0800, 32'h0000_0800);
		xfer(1'b0, 32'h0, 32'h0, 32'h0000_0800);
		gpio <= 12'h0;
		tick(3);
		hsize <= 3'h0;
		xfer(1'b1, 32'h0, 32'h0000_0800, 32'h0);
		hsize <= ISB_HSIZE_WORD;
		xfer(1'b0, 32'h0, 32'h0, 32'h0000_0800);
		xfer(1'b1, 32'h0, 32'h0000_0800, 32'h0000_0800);
		$display("test gpio done");
		xfer(1'b1, 32'h4, 32'h0001_0000, 32'h0);
		pulse_dp();
		xfer(1'b1, 32'h0, 32'h0, 32'h0000_1000);
		xfer(1'b1, 32'h0, 32'h0001_0000, 32'h0000_1000);
		xfer(1'b1, 32'h4, 32'h0, 32'h0);
		pulse_dp();
		xfer(1'b1, 32'h0, 32'h0001_0000, 32'h0);
		$display("test interrupt done");
		gpio <= 12'h0a5;
		reset_n <= 1'b0;
		tick(2);
		reset_n <= 1'b1;
		tick(4);
		xfer(1'b0, 32'h0, 32'h0, 32'h0000_00a5);
		$display("test reset with pins done");
		wrap_up();
	end
endmodule
`default_nettype wire
